// [verilog/nco_pkg.sv]
// constants, register map and field layout of the numeric oscillator
package nco_pkg;
    localparam int ACC_W = 20;
    localparam logic [3:0] OFF_CONTROL = 4'h0;
    localparam logic [3:0] OFF_CLOCK_CFG = 4'h1;
    localparam logic [3:0] OFF_ACC_LOW = 4'h2;
    localparam logic [3:0] OFF_ACC_HIGH = 4'h3;
    localparam logic [3:0] OFF_ACC_UPPER = 4'h4;
    localparam logic [3:0] OFF_INC_LOW = 4'h5;
    localparam logic [3:0] OFF_INC_HIGH = 4'h6;
    localparam logic [3:0] OFF_INC_UPPER = 4'h7;
    localparam logic [3:0] OFF_IRQ = 4'h8;
    localparam int BIT_PULSE_MODE = 0;
    localparam int BIT_POLARITY = 4;
    localparam int BIT_OUT_LEVEL = 5;
    localparam int BIT_ENABLE = 7;
    localparam int PWS_LSB = 5;
    localparam int CKS_LSB = 0;
    localparam int BIT_IRQ_FLAG = 0;
    localparam int BIT_IRQ_ENABLE = 1;
    localparam int BIT_PERIPH_EN = 2;
    localparam int BIT_GLOBAL_EN = 3;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] CONTROL_WMASK = 8'h91;
    localparam logic [7:0] CLOCK_CFG_WMASK = 8'hE3;
    localparam logic [1:0] INC_LOAD_EDGES = 2'h2;
    typedef enum logic [1:0] {
        SRC_FAST_OSC = 2'b00,
        SRC_SYS_OSC = 2'b01,
        SRC_LOGIC_CELL = 2'b10
    } clk_src_t;
endpackage

// [verilog/nco_edge_detect.sv]
// rising-edge detector for the selected oscillator input clock
`timescale 1ns/1ps
module nco_edge_detect (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // sampled clock level and edge pulse
    input wire logic level_in,
    output logic rise
);
    logic prev_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= level_in;
        end
    end

    assign rise = level_in & ~prev_r;
endmodule

// [verilog/numeric_oscillator.sv]
// numerically controlled oscillator: accumulator, increment buffers, output stage, registers
// Operation
// - 20-bit accumulator, carry-out is overflow
// - carry drives output stage and flag
// - clock source chosen from three inputs
// - accumulator readable and writable as three bytes
// - each input edge adds buffered increment
// - 20-bit increment in low/high/upper bytes
// - low write loads buffers on second edge
// - adder uses hidden increment buffer only
// - disabled: buffers load right after write
// - fixed duty mode toggles on overflow
// - control bit 0 selects pulse mode
// - pulse starts on the overflow edge
// - pulse width is two to code periods
// - too-long pulse keeps output active
// - control bit 4 inverts output
// - polarity change raises flag on transition when irq enable is set
// - control bit 5 shows output level
// - overflow sets flag, request needs enables
// - flag sticks until software clears it
// - control bit 7 enables the oscillator
// - reset clears every register to zero
// - keeps running in sleep, fast osc held while enabled with it selected
`timescale 1ns/1ps
module numeric_oscillator
    import nco_pkg::*;
#(
    parameter int WIDTH = ACC_W
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // register port
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // oscillator input clock levels, sampled on SYS_CLK
    input wire logic FAST_OSC_CLK,
    input wire logic SYS_OSC_CLK,
    input wire logic LOGIC_CELL_OUT,
    // sleep state of the core
    input wire logic SLEEP,
    // outputs
    output logic OSC_OUT,
    output logic OVERFLOW_IRQ,
    output logic FAST_OSC_KEEP
);
    // byte lanes below are fixed at 20 bits, so any other width is refused
    if (WIDTH != ACC_W) begin : g_width_check
        $error("numeric_oscillator supports only a 20-bit accumulator");
    end

    logic [7:0] control_r;
    logic [7:0] clock_cfg_r;
    logic [WIDTH-1:0] acc_r;
    logic [WIDTH-1:0] inc_r;
    logic [WIDTH-1:0] inc_buf_r;
    logic [3:0] irq_r;
    logic [7:0] rdata_r;
    logic [1:0] load_cnt_r;
    logic load_pend_r;
    logic fdc_r;
    logic pulse_r;
    logic [7:0] pulse_cnt_r;
    logic out_final_r;
    logic pol_chg_r;

    logic enabled;
    logic pulse_mode;
    logic polarity;
    logic [2:0] pws;
    logic [1:0] cks;
    logic src_level;
    logic in_edge;
    logic [WIDTH:0] sum;
    logic carry;
    logic raw_out;
    logic [7:0] width_cnt;
    logic wr_ctl;
    logic wr_inc;
    logic wr_inc_low;
    logic wr_inc_high;
    logic wr_inc_upper;
    logic wr_clk_cfg;
    logic wr_irq;
    logic wr_acc_low;
    logic wr_acc_high;
    logic wr_acc_upper;
    logic out_final_nxt;

    assign enabled = control_r[BIT_ENABLE];
    assign pulse_mode = control_r[BIT_PULSE_MODE];
    assign polarity = control_r[BIT_POLARITY];
    assign pws = clock_cfg_r[PWS_LSB +: 3];
    assign cks = clock_cfg_r[CKS_LSB +: 2];

    // register write strobes
    assign wr_ctl = WR && (ADDR == OFF_CONTROL);
    assign wr_clk_cfg = WR && (ADDR == OFF_CLOCK_CFG);
    assign wr_irq = WR && (ADDR == OFF_IRQ);
    assign wr_acc_low = WR && (ADDR == OFF_ACC_LOW);
    assign wr_acc_high = WR && (ADDR == OFF_ACC_HIGH);
    assign wr_acc_upper = WR && (ADDR == OFF_ACC_UPPER);
    assign wr_inc_low = WR && (ADDR == OFF_INC_LOW);
    assign wr_inc_high = WR && (ADDR == OFF_INC_HIGH);
    assign wr_inc_upper = WR && (ADDR == OFF_INC_UPPER);
    assign wr_inc = wr_inc_low || wr_inc_high || wr_inc_upper;

    always_comb begin
        unique case (cks)
            SRC_FAST_OSC: src_level = FAST_OSC_CLK;
            SRC_SYS_OSC: src_level = SYS_OSC_CLK;
            SRC_LOGIC_CELL: src_level = LOGIC_CELL_OUT;
            // code 3 is reserved and selects a quiet level
            default: src_level = 1'b0;
        endcase
    end

    // source levels are sampled, so each must stay below half of SYS_CLK
    nco_edge_detect u_edge (
        .clk(SYS_CLK),
        .rst(RST),
        .level_in(src_level),
        .rise(in_edge)
    );

    assign sum = {1'b0, acc_r} + {1'b0, inc_buf_r};
    // only an add can overflow; a software write to the accumulator never does
    // carry is overflow
    assign carry = enabled && in_edge && sum[WIDTH];
    assign width_cnt = 8'(1 << pws);

    // SLEEP is left unread on purpose: nothing here stops in sleep
    // sleep does not gate the oscillator path
    assign FAST_OSC_KEEP = enabled && (cks == SRC_FAST_OSC);

    // control and clock config reset to zero
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            control_r <= RESET_BYTE;
            clock_cfg_r <= RESET_BYTE;
        end else if (wr_ctl) begin
            // read-only and unused bits are masked so writes leave them; unused bits read back as zero, bit 5 reads the output level
            // enable bit written here
            control_r <= (WDATA & CONTROL_WMASK) | (control_r & ~CONTROL_WMASK);
        end else if (wr_clk_cfg) begin
            clock_cfg_r <= WDATA & CLOCK_CFG_WMASK;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            inc_r <= '0;
        end else if (WR) begin
            if (ADDR == OFF_INC_LOW) begin
                inc_r[7:0] <= WDATA;
            end else if (ADDR == OFF_INC_HIGH) begin
                inc_r[15:8] <= WDATA;
            end else if (ADDR == OFF_INC_UPPER) begin
                inc_r[19:16] <= WDATA[3:0];
            end
        end
    end

    // the two-edge wait keeps the swap clear of the edge that saw the write
    // low write arms a load on the second input edge
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            load_pend_r <= 1'b0;
            load_cnt_r <= 2'h0;
        end else if (!enabled) begin
            load_pend_r <= 1'b0;
            load_cnt_r <= 2'h0;
        end else if (wr_inc_low) begin
            load_pend_r <= 1'b1;
            load_cnt_r <= 2'h0;
        end else if (load_pend_r && in_edge) begin
            if (load_cnt_r == INC_LOAD_EDGES - 2'h1) begin
                load_pend_r <= 1'b0;
                load_cnt_r <= 2'h0;
            end else begin
                load_cnt_r <= load_cnt_r + 2'h1;
            end
        end
    end

    // copying every cycle while disabled covers writes in any byte order
    // hidden increment buffer
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            inc_buf_r <= '0;
        end else if (!enabled) begin
            if (load_pend_r || wr_inc) begin
                inc_buf_r <= inc_r;
            end else begin
                inc_buf_r <= inc_r;
            end
        end else if (load_pend_r && in_edge && load_cnt_r == INC_LOAD_EDGES - 2'h1) begin
            inc_buf_r <= inc_r;
        end
    end

    // software writes win over a concurrent add so a loaded value is kept
    // accumulator
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            acc_r <= '0;
        end else if (wr_acc_low) begin
            acc_r[7:0] <= WDATA;
        end else if (wr_acc_high) begin
            acc_r[15:8] <= WDATA;
        end else if (wr_acc_upper) begin
            acc_r[19:16] <= WDATA[3:0];
        end else if (enabled && in_edge) begin
            acc_r <= sum[WIDTH-1:0];
        end
    end

    // a disable parks the toggle low so a restart begins in a known phase
    // fixed duty toggle
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            fdc_r <= 1'b0;
        end else if (!enabled) begin
            fdc_r <= 1'b0;
        end else if (carry) begin
            fdc_r <= ~fdc_r;
        end
    end

    // eight count bits cover the widest pulse of 128 periods
    // pulse active from the overflow edge
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            pulse_r <= 1'b0;
            pulse_cnt_r <= 8'h00;
        end else if (!enabled) begin
            pulse_r <= 1'b0;
            pulse_cnt_r <= 8'h00;
        end else if (carry) begin
            pulse_r <= 1'b1;
            pulse_cnt_r <= width_cnt;
        end else if (in_edge && pulse_r) begin
            if (pulse_cnt_r <= 8'h01) begin
                pulse_r <= 1'b0;
                pulse_cnt_r <= 8'h00;
            end else begin
                pulse_cnt_r <= pulse_cnt_r - 8'h01;
            end
        end
    end

    assign raw_out = pulse_mode ? pulse_r : fdc_r;

    assign out_final_nxt = (enabled ? raw_out : 1'b0) ^ polarity;

    // status bit and pin share one flop so they always agree
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            out_final_r <= 1'b0;
        end else begin
            out_final_r <= out_final_nxt;
        end
    end

    assign OSC_OUT = out_final_r;

    // interrupt flag and enables
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            irq_r <= 4'h0;
        end else begin
            if (wr_irq) begin
                irq_r <= WDATA[3:0];
            end
            if (carry) begin
                irq_r[BIT_IRQ_FLAG] <= 1'b1;
            end
            // flagged in the cycle the new polarity reaches the output flop
            // polarity-caused transition flags when irq enable is set
            if (irq_r[BIT_IRQ_ENABLE] && pol_chg_r && (out_final_nxt != out_final_r)) begin
                irq_r[BIT_IRQ_FLAG] <= 1'b1;
            end
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            pol_chg_r <= 1'b0;
        end else begin
            pol_chg_r <= wr_ctl && (WDATA[BIT_POLARITY] != polarity);
        end
    end

    assign OVERFLOW_IRQ = irq_r[BIT_IRQ_FLAG] && enabled && irq_r[BIT_IRQ_ENABLE]
        && irq_r[BIT_PERIPH_EN] && irq_r[BIT_GLOBAL_EN];

    // idle cycles return zero so several read ports can be or-ed together
    // read data one cycle after strobe
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            rdata_r <= 8'h00;
        end else if (RD) begin
            case (ADDR)
                OFF_CONTROL: rdata_r <= {control_r[7:6], out_final_r, control_r[4:0]};
                OFF_CLOCK_CFG: rdata_r <= clock_cfg_r;
                OFF_ACC_LOW: rdata_r <= acc_r[7:0];
                OFF_ACC_HIGH: rdata_r <= acc_r[15:8];
                OFF_ACC_UPPER: rdata_r <= {4'h0, acc_r[19:16]};
                OFF_INC_LOW: rdata_r <= inc_r[7:0];
                OFF_INC_HIGH: rdata_r <= inc_r[15:8];
                OFF_INC_UPPER: rdata_r <= {4'h0, inc_r[19:16]};
                OFF_IRQ: rdata_r <= {4'h0, irq_r};
                default: rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign RDATA = rdata_r;
endmodule

// [test/nco_checker.sv]
// concurrent checks on the numeric oscillator ports
`timescale 1ns/1ps
module nco_checker
    import nco_pkg::*;
(
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // register port
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    // outputs
    input wire logic OSC_OUT,
    input wire logic OVERFLOW_IRQ,
    input wire logic FAST_OSC_KEEP
);
    logic [7:0] ctl_r;
    logic [7:0] cfg_r;
    logic [3:1] ien_r;

    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    // software-owned fields only; hardware flags are judged through the outputs
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ctl_r <= 8'h00;
            cfg_r <= 8'h00;
            ien_r <= 3'h0;
        end else if (WR) begin
            if (ADDR == OFF_CONTROL) ctl_r <= WDATA & CONTROL_WMASK;
            if (ADDR == OFF_CLOCK_CFG) cfg_r <= WDATA & CLOCK_CFG_WMASK;
            if (ADDR == OFF_IRQ) ien_r <= WDATA[3:1];
        end
    end

    a_rdata_idle_zero:
        assert property (!$past(RD) |-> RDATA == 8'h00) else $error("read data not zero outside read slot");
    a_control_read_back:
        assert property (RD && ADDR == OFF_CONTROL |=> RDATA == {$past(ctl_r[7]), 1'b0, $past(OSC_OUT),
            $past(ctl_r[4]), 3'h0, $past(ctl_r[0])}) else $error("control read back wrong");
    a_clock_cfg_read:
        assert property (RD && ADDR == OFF_CLOCK_CFG |=> RDATA == $past(cfg_r)) else $error("clock cfg read wrong");
    a_irq_enables_read:
        assert property (RD && ADDR == OFF_IRQ |=> RDATA[7:1] == {4'h0, $past(ien_r)})
            else $error("irq enables read wrong");
    a_keep_fast_osc:
        assert property (FAST_OSC_KEEP == (ctl_r[7] && cfg_r[1:0] == 2'b00)) else $error("fast osc keep wrong");
    a_irq_gated:
        assert property (OVERFLOW_IRQ |-> ctl_r[7] && (&ien_r)) else $error("irq request without all enables");
    a_irq_flag_holds:
        assert property (OVERFLOW_IRQ && !(WR && (ADDR == OFF_IRQ || ADDR == OFF_CONTROL)) |=> OVERFLOW_IRQ)
            else $error("irq request dropped without software");
    a_idle_output_level:
        assert property ((!ctl_r[7] && $stable(ctl_r[4])) [*3] |-> OSC_OUT == ctl_r[4])
            else $error("disabled output not at inactive level");
endmodule

// [test/tb.sv]
// self-checking bench for the numeric oscillator
`timescale 1ns/1ps
module tb;
    import nco_pkg::*;
    logic SYS_CLK;
    logic RST;
    logic [3:0] ADDR;
    logic [7:0] WDATA;
    logic WR;
    logic RD;
    logic [7:0] RDATA;
    logic [2:0] src_lv;
    logic SLEEP;
    logic OSC_OUT;
    logic OVERFLOW_IRQ;
    logic FAST_OSC_KEEP;
    int err_total = 0;
    int tests_run = 0;
    int cycles = 0;
    int highs;
    logic [7:0] rv;
    logic [19:0] acc_a;
    logic [19:0] acc_b;
    int codes[3] = '{0, 1, 7};
    int exps[3] = '{2, 4, 8};

    numeric_oscillator dut (.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .FAST_OSC_CLK(src_lv[0]), .SYS_OSC_CLK(src_lv[1]), .LOGIC_CELL_OUT(src_lv[2]),
        .SLEEP(SLEEP), .OSC_OUT(OSC_OUT), .OVERFLOW_IRQ(OVERFLOW_IRQ), .FAST_OSC_KEEP(FAST_OSC_KEEP));

    initial begin
        SYS_CLK = 1'b0;
        forever #12.5 SYS_CLK = ~SYS_CLK;
    end

    // the whole run needs roughly 700 cycles
    always @(posedge SYS_CLK) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            err_total++;
            $display("BAD t=%0t run timed out", $time);
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge SYS_CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge SYS_CLK);
        WR <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge SYS_CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge SYS_CLK);
        RD <= 1'b0;
        #1;
        d = RDATA;
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
        rd(a, rv);
        chk({12'h000, rv}, {12'h000, e});
    endtask

    // an enabled block then never adds a half-written value
    // upper, high, then low
    task automatic wr20(input logic [3:0] base, input logic [19:0] v);
        wr(base + 4'h2, {4'h0, v[19:16]});
        wr(base + 4'h1, v[15:8]);
        wr(base, v[7:0]);
    endtask

    task automatic rd_acc(output logic [19:0] v);
        logic [7:0] lo;
        logic [7:0] hi;
        logic [7:0] up;
        rd(OFF_ACC_LOW, lo);
        rd(OFF_ACC_HIGH, hi);
        rd(OFF_ACC_UPPER, up);
        v = {up[3:0], hi, lo};
    endtask

    // source periods of 9 system cycles; output sampled late in the high phase
    task automatic edges(input int s, input int n);
        repeat (n) begin
            @(posedge SYS_CLK);
            src_lv[s] <= 1'b1;
            repeat (4) @(posedge SYS_CLK);
            #1;
            if (OSC_OUT === 1'b1) highs++;
            src_lv[s] <= 1'b0;
            repeat (4) @(posedge SYS_CLK);
        end
        #1;
    endtask

    initial begin
        RST = 1'b1;
        ADDR = 4'h0;
        WDATA = 8'h00;
        WR = 1'b0;
        RD = 1'b0;
        src_lv = 3'h0;
        SLEEP = 1'b0;
        repeat (2) @(posedge SYS_CLK);
        RST <= 1'b0;
        for (int a = 0; a < 9; a++) rdchk(a[3:0], 8'h00);
        rdchk(4'hF, 8'h00);
        $display("test reset values done");
        wr(OFF_CONTROL, 8'h7F);
        rdchk(OFF_CONTROL, 8'h31);
        wr(OFF_CONTROL, 8'h00);
        wr(OFF_CLOCK_CFG, 8'hFF);
        rdchk(OFF_CLOCK_CFG, 8'hE3);
        wr20(OFF_INC_LOW, 20'hABCDE);
        rdchk(OFF_INC_UPPER, 8'h0A);
        rdchk(OFF_INC_HIGH, 8'hBC);
        rdchk(OFF_INC_LOW, 8'hDE);
        wr20(OFF_ACC_LOW, 20'h12345);
        rd_acc(acc_a);
        chk(acc_a, 20'h12345);
        $display("test register access done");
        SLEEP <= 1'b1;
        wr(OFF_CLOCK_CFG, 8'h01);
        wr20(OFF_INC_LOW, 20'h80000);
        wr20(OFF_ACC_LOW, 20'h00000);
        wr(OFF_IRQ, 8'h0E);
        wr(OFF_CONTROL, 8'h80);
        edges(1, 2);
        chk({19'h0, OSC_OUT}, 20'h1);
        chk({19'h0, OVERFLOW_IRQ}, 20'h1);
        rdchk(OFF_IRQ, 8'h0F);
        edges(1, 1);
        rd_acc(acc_a);
        chk(acc_a, 20'h80000);
        edges(1, 1);
        chk({19'h0, OSC_OUT}, 20'h0);
        wr(OFF_IRQ, 8'h0E);
        rdchk(OFF_IRQ, 8'h0E);
        edges(2, 2);
        rd_acc(acc_a);
        chk(acc_a, 20'h00000);
        wr20(OFF_INC_LOW, 20'h00001);
        edges(1, 1);
        rd_acc(acc_a);
        chk(acc_a, 20'h80000);
        edges(1, 2);
        rd_acc(acc_a);
        edges(1, 1);
        rd_acc(acc_b);
        chk(acc_b - acc_a, 20'h00001);
        $display("test fixed duty and buffering done");
        wr(OFF_CONTROL, 8'h00);
        wr(OFF_IRQ, 8'h02);
        wr(OFF_CONTROL, 8'h10);
        rdchk(OFF_IRQ, 8'h03);
        chk({19'h0, OSC_OUT}, 20'h1);
        $display("test polarity done");
        for (int i = 0; i < 3; i++) begin
            wr(OFF_CONTROL, 8'h00);
            wr20(OFF_INC_LOW, 20'h40000);
            wr20(OFF_ACC_LOW, 20'h00000);
            wr(OFF_CLOCK_CFG, {codes[i][2:0], 5'h01});
            wr(OFF_CONTROL, 8'h81);
            edges(1, 1);
            rd_acc(acc_a);
            chk(acc_a, 20'h40000);
            edges(1, 5);
            highs = 0;
            edges(1, 8);
            chk(highs[19:0], exps[i][19:0]);
        end
        $display("test pulse mode done");
        wr(OFF_CLOCK_CFG, 8'h00);
        wr(OFF_CONTROL, 8'h80);
        #1;
        chk({19'h0, FAST_OSC_KEEP}, 20'h1);
        $display("test sleep keep done");
        RST <= 1'b1;
        @(posedge SYS_CLK);
        RST <= 1'b0;
        rdchk(OFF_CONTROL, 8'h00);
        rdchk(OFF_INC_UPPER, 8'h00);
        rdchk(OFF_IRQ, 8'h00);
        rd_acc(acc_a);
        chk(acc_a, 20'h00000);
        $display("test second reset done");
        test_done();
    end
endmodule

bind numeric_oscillator nco_checker chk_i (.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .OSC_OUT(OSC_OUT), .OVERFLOW_IRQ(OVERFLOW_IRQ), .FAST_OSC_KEEP(FAST_OSC_KEEP));
